// ==== hdl/vrc_defines.svh ====
// Constants for the voltage reference control block
// Notes on behaviour
// - Writing one to the enable bit turns the fixed reference on, and it stays off while the bit is zero.
// - Once enabled, the ready flag is set after the reference and buffer have settled, which here is immediate.
// - The ready flag reads one when the reference is usable and zero when it is not ready or not enabled.
// - Gain field 11 selects 4x, 10 selects 2x, 01 selects 1x and 00 turns the buffer off.
// - The gain field both enables the converter-path buffer and selects its gain, apart from other paths.
// - The buffered reference is offered to the converter as positive reference and as an input channel.
// - Enable sits at bit 7, ready at bit 6, gain at bits 1:0, bits 5:2 are unimplemented, all clear on reset.
`ifndef VRC_DEFINES_SVH
`define VRC_DEFINES_SVH
`define VRC_ADDR_W 12
`define VRC_CTRL_ADDR 12'h90C
`define VRC_EN_BIT 7
`define VRC_RDY_BIT 6
`define VRC_GAIN_HI 1
`define VRC_GAIN_LO 0
`define VRC_UNIMPL_HI 5
`define VRC_UNIMPL_LO 2
`define VRC_GAIN_RESET 2'h0
`define VRC_SETTLE_CYCLES 1
`define VRC_GAIN_OFF 2'h0
`define VRC_GAIN_X1 2'h1
`define VRC_GAIN_X2 2'h2
`define VRC_GAIN_X4 2'h3
`endif

// ==== hdl/vrc_pkg.sv ====
// Types for the voltage reference control block
package vrc_pkg;
  typedef logic [1:0] vrc_gain_type;
  typedef logic [7:0] vrc_data_type;
  typedef logic [11:0] vrc_addr_type;
endpackage

// ==== hdl/vrc_control.sv ====
// Register and control logic for the fixed voltage reference
`timescale 1ns/1ps
`include "vrc_defines.svh"
module vrc_control (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire vrc_pkg::vrc_addr_type addr,
  input wire vrc_pkg::vrc_data_type wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output vrc_pkg::vrc_data_type rdData,
  // Analog controls
  output logic referenceEnable,
  output logic bufferEnable,
  output vrc_pkg::vrc_gain_type converterBufferGain,
  output logic converterRefValid
);
  import vrc_pkg::*;

  logic enable_q;
  logic enable_d;
  vrc_gain_type gain_q;
  vrc_gain_type gain_d;
  logic ready_q;
  logic ready_d;
  vrc_data_type rdData_d;
  logic ctrlHit;

  // Address decode and next values
  assign ctrlHit = (addr == `VRC_CTRL_ADDR);
  assign enable_d = (wrStrobe && ctrlHit) ? wrData[`VRC_EN_BIT] : enable_q;
  assign gain_d = (wrStrobe && ctrlHit) ? wrData[`VRC_GAIN_HI:`VRC_GAIN_LO] : gain_q;
  assign ready_d = enable_d;

  // Read data: bits 5:2 read zero, unmapped reads zero
  always_comb begin
    rdData_d = '0;
    if (rdStrobe && ctrlHit) begin
      rdData_d[`VRC_EN_BIT] = enable_q;
      rdData_d[`VRC_RDY_BIT] = ready_q;
      rdData_d[`VRC_GAIN_HI:`VRC_GAIN_LO] = gain_q;
    end
  end

  // Control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_q <= 1'b0;
      gain_q <= `VRC_GAIN_RESET;
      ready_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      gain_q <= gain_d;
      ready_q <= ready_d;
    end
  end

  // Registered outputs toward the analog reference and converter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= '0;
      referenceEnable <= 1'b0;
      bufferEnable <= 1'b0;
      converterBufferGain <= `VRC_GAIN_OFF;
      converterRefValid <= 1'b0;
    end else begin
      rdData <= rdData_d;
      referenceEnable <= enable_d;
      bufferEnable <= (gain_d != `VRC_GAIN_OFF);
      converterBufferGain <= gain_d;
      converterRefValid <= enable_d && (gain_d != `VRC_GAIN_OFF);
    end
  end

  // Checks
  property p_enable_follows;
    @(posedge clk) disable iff (!nrst)
      (wrStrobe && ctrlHit) |=> (referenceEnable == $past(wrData[`VRC_EN_BIT]));
  endproperty
  a_enable_follows: assert property (p_enable_follows) else $error("enable did not follow write");

  property p_ready_tracks;
    @(posedge clk) disable iff (!nrst) rdStrobe && ctrlHit |=> rdData[`VRC_RDY_BIT] == $past(enable_q);
  endproperty
  a_ready_tracks: assert property (p_ready_tracks) else $error("ready flag wrong");

  property p_ready_after_enable;
    @(posedge clk) disable iff (!nrst) $rose(enable_q) |-> ready_q;
  endproperty
  a_ready_after_enable: assert property (p_ready_after_enable) else $error("ready not set");

  property p_gain_write;
    @(posedge clk) disable iff (!nrst)
      (wrStrobe && ctrlHit) |=> converterBufferGain == $past(wrData[`VRC_GAIN_HI:`VRC_GAIN_LO]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain not written");

  property p_buffer_enable;
    @(posedge clk) disable iff (!nrst) bufferEnable == (converterBufferGain != `VRC_GAIN_OFF);
  endproperty
  a_buffer_enable: assert property (p_buffer_enable) else $error("buffer enable mismatch");

  property p_ref_valid;
    @(posedge clk) disable iff (!nrst) converterRefValid == (referenceEnable && bufferEnable);
  endproperty
  a_ref_valid: assert property (p_ref_valid) else $error("converter reference valid wrong");

  property p_read_layout;
    @(posedge clk) disable iff (!nrst)
      rdStrobe && ctrlHit |=> rdData[`VRC_EN_BIT] == $past(enable_q) &&
        rdData[`VRC_GAIN_HI:`VRC_GAIN_LO] == $past(gain_q);
  endproperty
  a_read_layout: assert property (p_read_layout) else $error("read layout wrong");

  property p_unimpl_zero;
    @(posedge clk) disable iff (!nrst) rdData[`VRC_UNIMPL_HI:`VRC_UNIMPL_LO] == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits not zero");

  // Named steps of a register access, shared by the checks below
  sequence s_ctrl_write;
    wrStrobe && ctrlHit;
  endsequence

  sequence s_ctrl_read;
    rdStrobe && ctrlHit;
  endsequence

  sequence s_other_write;
    wrStrobe && !ctrlHit;
  endsequence

  sequence s_no_write;
    !wrStrobe;
  endsequence

  // Enable holds while nothing is written
  property p_enable_holds;
    @(posedge clk) disable iff (!nrst) s_no_write |=> $stable(referenceEnable);
  endproperty
  a_enable_holds: assert property (p_enable_holds) else $error("enable moved without a write");

  // A write to another address leaves the controls alone
  property p_other_write_ignored;
    @(posedge clk) disable iff (!nrst)
      s_other_write |=> $stable(referenceEnable) && $stable(converterBufferGain);
  endproperty
  a_other_write_ignored: assert property (p_other_write_ignored) else $error("foreign write changed controls");

  // Gain holds while nothing is written
  property p_gain_holds;
    @(posedge clk) disable iff (!nrst) s_no_write |=> $stable(converterBufferGain);
  endproperty
  a_gain_holds: assert property (p_gain_holds) else $error("gain moved without a write");

  // Gain off means buffer off and no usable converter reference
  property p_buffer_off;
    @(posedge clk) disable iff (!nrst)
      (converterBufferGain == `VRC_GAIN_OFF) |-> !bufferEnable && !converterRefValid;
  endproperty
  a_buffer_off: assert property (p_buffer_off) else $error("buffer on with gain off");

  // Ready reads back set right after an enabling write
  property p_ready_after_write;
    @(posedge clk) disable iff (!nrst)
      s_ctrl_write ##1 s_ctrl_read |=> rdData[`VRC_RDY_BIT] == $past(wrData[`VRC_EN_BIT], 2);
  endproperty
  a_ready_after_write: assert property (p_ready_after_write) else $error("ready late after write");

  // Read data stays zero outside the cycle after a read
  property p_read_idle_zero;
    @(posedge clk) disable iff (!nrst) !(rdStrobe && ctrlHit) |=> rdData == '0;
  endproperty
  a_read_idle_zero: assert property (p_read_idle_zero) else $error("read data not zero when idle");

  // Reads of other addresses return zero
  property p_unmapped_read_zero;
    @(posedge clk) disable iff (!nrst) (rdStrobe && !ctrlHit) |=> rdData == '0;
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read not zero");

  // The converter never sees a valid reference while it is off
  property p_valid_needs_enable;
    @(posedge clk) disable iff (!nrst) converterRefValid |-> referenceEnable;
  endproperty
  a_valid_needs_enable: assert property (p_valid_needs_enable) else $error("valid without enable");

  // Ready reads as the enable state, zero while disabled
  property p_ready_matches_enable;
    @(posedge clk) disable iff (!nrst)
      s_ctrl_read |=> rdData[`VRC_RDY_BIT] == rdData[`VRC_EN_BIT];
  endproperty
  a_ready_matches_enable: assert property (p_ready_matches_enable) else $error("ready differs from enable");

  // A written gain reads back on a read right behind the write
  property p_gain_readback;
    @(posedge clk) disable iff (!nrst)
      s_ctrl_write ##1 s_ctrl_read |=>
        rdData[`VRC_GAIN_HI:`VRC_GAIN_LO] == $past(wrData[`VRC_GAIN_HI:`VRC_GAIN_LO], 2);
  endproperty
  a_gain_readback: assert property (p_gain_readback) else $error("gain read back wrong");

  // Buffer enable follows the written gain code
  property p_buffer_after_write;
    @(posedge clk) disable iff (!nrst)
      s_ctrl_write |=> bufferEnable == ($past(wrData[`VRC_GAIN_HI:`VRC_GAIN_LO]) != `VRC_GAIN_OFF);
  endproperty
  a_buffer_after_write: assert property (p_buffer_after_write) else $error("buffer enable not written");

  // Converter reference valid follows enable and gain of the write
  property p_valid_after_write;
    @(posedge clk) disable iff (!nrst)
      s_ctrl_write |=> converterRefValid ==
        ($past(wrData[`VRC_EN_BIT]) && ($past(wrData[`VRC_GAIN_HI:`VRC_GAIN_LO]) != `VRC_GAIN_OFF));
  endproperty
  a_valid_after_write: assert property (p_valid_after_write) else $error("valid not written");
endmodule // vrc_control

// ==== bench/tb.sv ====
// Self-checking bench for the voltage reference control block
`timescale 1ns/1ps
`include "vrc_defines.svh"
module tb;
  import vrc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic rdPend = 1'b0;
  vrc_addr_type addr = 12'h000;
  vrc_data_type wrData = 8'h00;
  vrc_data_type rdData, v;
  logic referenceEnable, bufferEnable, converterRefValid;
  vrc_gain_type converterBufferGain;
  vrc_data_type expQ[$];
  int nErrors = 0;
  int numChecks = 0;
  vrc_control u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .referenceEnable(referenceEnable), .bufferEnable(bufferEnable),
    .converterBufferGain(converterBufferGain), .converterRefValid(converterRefValid));
  // Clock with a 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    if (nErrors == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One-cycle bus accesses; a read also notes its expected byte
  task wr(input vrc_addr_type a, input vrc_data_type d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task rd(input vrc_addr_type a, input vrc_data_type e);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    rdStrobe <= 1'b0;
  endtask
  // Read data is compared mid-cycle, in the one cycle it stands
  always @(posedge clk) rdPend <= rdStrobe;
  always @(negedge clk) begin
    if (rdPend && expQ.size() > 0) chk("rdData", rdData, expQ.pop_front());
  end
  // Main sequence: every gain code, random enable and junk in bits 6:2
  initial begin
    void'($urandom(32'h06f1247f));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(`VRC_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[1:0] = i[1:0];
      wr(`VRC_CTRL_ADDR, v);
      @(negedge clk);
      chk("controls", {referenceEnable, bufferEnable, converterRefValid, 3'h0, converterBufferGain},
        {v[7], v[1:0] != 2'h0, v[7] && v[1:0] != 2'h0, 3'h0, v[1:0]});
      rd(`VRC_CTRL_ADDR, {v[7], v[7], 4'h0, v[1:0]});
    end
    // Write then read back to back
    @(posedge clk);
    addr <= `VRC_CTRL_ADDR;
    wrData <= 8'h82;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b1;
    expQ.push_back(8'hC2);
    @(posedge clk);
    rdStrobe <= 1'b0;
    wr(12'h90B, 8'hFF);
    rd(12'h90B, 8'h00);
    rd(`VRC_CTRL_ADDR, 8'hC2);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`VRC_CTRL_ADDR, 8'h00);
    for (int k = 0; k < 10 && expQ.size() > 0; k++) @(posedge clk);
    if (expQ.size() > 0) nErrors++;
    print_verdict();
  end
endmodule // tb
